// ### core/ppl_pkg.sv
// Package for the port pull-up and latch block: offsets, reset values, masks, carriers
package ppl_pkg;
    // Register indices; each register owns one 32-bit word at byte address four times its index
    localparam logic [15:0] PORT_DATA_P2_IDX    = 16'hFF08;
    localparam logic [15:0] PORT_DATA_P3_IDX    = 16'hFF0C;
    localparam logic [15:0] PORT_DATA_P4_IDX    = 16'hFF10;
    localparam logic [15:0] PORT_DIR_P2_IDX     = 16'hFF20;
    localparam logic [15:0] PORT_DIR_P3_IDX     = 16'hFF24;
    localparam logic [15:0] PORT_DIR_P4_IDX     = 16'hFF28;
    localparam logic [15:0] PULLUP_SEL_P2_IDX   = 16'hFF32;
    localparam logic [15:0] PULLUP_SEL_P3_IDX   = 16'hFF33;
    localparam logic [15:0] PULLUP_SEL_P4_IDX   = 16'hFF34;
    // Bit-operation register: one write sets or clears a single bit; on the latch, input pins also take their pin level
    localparam logic [15:0] BIT_OP_IDX          = 16'hFF40;
    // Implemented pins per port
    localparam logic [7:0]  PORT2_MASK          = 8'h0F;
    localparam logic [7:0]  PORT3_MASK          = 8'h04;
    localparam logic [7:0]  PORT4_MASK          = 8'hFF;
    // Reset values
    localparam logic [7:0]  PULLUP_RESET        = 8'h00;
    localparam logic [7:0]  LATCH_RESET         = 8'h00;
    localparam logic [7:0]  DIR_RESET           = 8'hFF;
    // Bit-operation word layout
    localparam int          BIT_OP_INDEX_LSB    = 0;
    localparam int          BIT_OP_VALUE_POS    = 3;
    localparam int          BIT_OP_TARGET_LSB   = 4;

    typedef enum logic [1:0] {
        PPL_TGT_LATCH  = 2'b00,
        PPL_TGT_DIR    = 2'b01,
        PPL_TGT_PULLUP = 2'b10,
        PPL_TGT_NONE   = 2'b11
    } ppl_target_e;

    // Pin-side signals of one port
    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] drive_en;
        logic [7:0] pullup_en;
    } ppl_pin_out_s;
endpackage

// ### core/ppl_port_block.sv
// Pull-up selection, direction and output latch logic for ports 2, 3 and 4 behind APB
`timescale 1ns/1ps
module ppl_port_block (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [17:0]            paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [7:0]             pin_in_p2,
    input  wire logic [7:0]             pin_in_p3,
    input  wire logic [7:0]             pin_in_p4,
    output ppl_pkg::ppl_pin_out_s       pins_p2,
    output ppl_pkg::ppl_pin_out_s       pins_p3,
    output ppl_pkg::ppl_pin_out_s       pins_p4
);
    localparam int BIT_IDX_MSB = ppl_pkg::BIT_OP_INDEX_LSB + 2;

    // Register state
    logic [7:0]  latch_p2;
    logic [7:0]  latch_p3;
    logic [7:0]  latch_p4;
    logic [7:0]  dir_p2;
    logic [7:0]  dir_p3;
    logic [7:0]  dir_p4;
    logic [7:0]  pullup_select_port2;
    logic [7:0]  pullup_select_port3;
    logic [7:0]  pullup_select_port4;

    // Pin synchronisers
    logic [7:0]  sync1_p2;
    logic [7:0]  sync1_p3;
    logic [7:0]  sync1_p4;
    logic [7:0]  pin_p2;
    logic [7:0]  pin_p3;
    logic [7:0]  pin_p4;

    // Bus decode
    logic        access;
    logic        wr;
    logic        wr_lane0;
    logic        bad_addr;
    logic [31:0] next_prdata;
    logic        sel_data_p2;
    logic        sel_data_p3;
    logic        sel_data_p4;
    logic        sel_dir_p2;
    logic        sel_dir_p3;
    logic        sel_dir_p4;
    logic        sel_pu_p2;
    logic        sel_pu_p3;
    logic        sel_pu_p4;
    logic        sel_bop;

    // Bit operation fields
    logic [1:0]  bop_port;
    logic [2:0]  bop_idx;
    logic        bop_val;
    logic [1:0]  bop_tgt;
    logic        bop_wr;
    logic        bop_p2;
    logic        bop_p3;
    logic        bop_p4;

    // One register per aligned word; a misaligned address matches nothing
    function automatic logic hit(input logic [17:0] addr, input logic [15:0] idx);
        hit = (addr[17:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    // Port view: pin level on inputs, latch on outputs
    function automatic logic [7:0] port_view(input logic [7:0] latch, input logic [7:0] dir,
                                             input logic [7:0] pin, input logic [7:0] mask);
        port_view = ((dir & pin) | (~dir & latch)) & mask;
    endfunction

    // Replace one bit of a byte-wide operand
    function automatic logic [7:0] bit_apply(input logic [7:0] operand, input logic [2:0] idx,
                                             input logic val);
        logic [7:0] res;
        res = operand;
        res[idx] = val;
        bit_apply = res;
    endfunction

    // Missing pins stay inputs so that they never drive
    function automatic logic [7:0] fill_unused(input logic [7:0] value, input logic [7:0] mask);
        fill_unused = value | ~mask;
    endfunction

    // A driven pin never also gets the pull-up: it would only waste current
    function automatic logic [7:0] pullup_gate(input logic [7:0] sel, input logic [7:0] dir);
        pullup_gate = sel & dir;
    endfunction

    assign access   = psel && penable;
    assign wr       = access && pwrite;
    assign wr_lane0 = wr && pstrb[0];
    assign pready   = 1'b1;
    assign pslverr  = access && bad_addr;

    assign sel_data_p2 = hit(paddr, ppl_pkg::PORT_DATA_P2_IDX);
    assign sel_data_p3 = hit(paddr, ppl_pkg::PORT_DATA_P3_IDX);
    assign sel_data_p4 = hit(paddr, ppl_pkg::PORT_DATA_P4_IDX);
    assign sel_dir_p2  = hit(paddr, ppl_pkg::PORT_DIR_P2_IDX);
    assign sel_dir_p3  = hit(paddr, ppl_pkg::PORT_DIR_P3_IDX);
    assign sel_dir_p4  = hit(paddr, ppl_pkg::PORT_DIR_P4_IDX);
    assign sel_pu_p2   = hit(paddr, ppl_pkg::PULLUP_SEL_P2_IDX);
    assign sel_pu_p3   = hit(paddr, ppl_pkg::PULLUP_SEL_P3_IDX);
    assign sel_pu_p4   = hit(paddr, ppl_pkg::PULLUP_SEL_P4_IDX);
    assign sel_bop     = hit(paddr, ppl_pkg::BIT_OP_IDX);

    // Bit operation decode: target, port, index, value
    assign bop_idx  = pwdata[BIT_IDX_MSB:ppl_pkg::BIT_OP_INDEX_LSB];
    assign bop_val  = pwdata[ppl_pkg::BIT_OP_VALUE_POS];
    assign bop_tgt  = pwdata[ppl_pkg::BIT_OP_TARGET_LSB +: 2];
    assign bop_port = pwdata[ppl_pkg::BIT_OP_TARGET_LSB + 2 +: 2];
    assign bop_wr   = wr_lane0 && sel_bop;
    assign bop_p2   = bop_wr && (bop_port == 2'd2);
    assign bop_p3   = bop_wr && (bop_port == 2'd3);
    assign bop_p4   = bop_wr && (bop_port == 2'd0);

    // Pin levels come from outside the pclk domain; two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_p2 <= 8'h00;
            sync1_p3 <= 8'h00;
            sync1_p4 <= 8'h00;
            pin_p2   <= 8'h00;
            pin_p3   <= 8'h00;
            pin_p4   <= 8'h00;
        end else begin
            sync1_p2 <= pin_in_p2;
            sync1_p3 <= pin_in_p3;
            sync1_p4 <= pin_in_p4;
            pin_p2   <= sync1_p2;
            pin_p3   <= sync1_p3;
            pin_p4   <= sync1_p4;
        end
    end

    // Latches load on writes whatever the direction; otherwise they hold.
    // Bit operations rewrite the whole byte from the port view, so input pins take pin level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_p2 <= ppl_pkg::LATCH_RESET;
        end else if (wr_lane0 && sel_data_p2) begin
            latch_p2 <= pwdata[7:0] & ppl_pkg::PORT2_MASK;
        end else if (bop_p2 && bop_tgt == ppl_pkg::PPL_TGT_LATCH) begin
            latch_p2 <= bit_apply(port_view(latch_p2, dir_p2, pin_p2, ppl_pkg::PORT2_MASK),
                                  bop_idx, bop_val) & ppl_pkg::PORT2_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_p3 <= ppl_pkg::LATCH_RESET;
        end else if (wr_lane0 && sel_data_p3) begin
            latch_p3 <= pwdata[7:0] & ppl_pkg::PORT3_MASK;
        end else if (bop_p3 && bop_tgt == ppl_pkg::PPL_TGT_LATCH) begin
            latch_p3 <= bit_apply(port_view(latch_p3, dir_p3, pin_p3, ppl_pkg::PORT3_MASK),
                                  bop_idx, bop_val) & ppl_pkg::PORT3_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_p4 <= ppl_pkg::LATCH_RESET;
        end else if (wr_lane0 && sel_data_p4) begin
            latch_p4 <= pwdata[7:0] & ppl_pkg::PORT4_MASK;
        end else if (bop_p4 && bop_tgt == ppl_pkg::PPL_TGT_LATCH) begin
            latch_p4 <= bit_apply(port_view(latch_p4, dir_p4, pin_p4, ppl_pkg::PORT4_MASK),
                                  bop_idx, bop_val) & ppl_pkg::PORT4_MASK;
        end
    end

    // Direction registers; unimplemented bits stay 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_p2 <= ppl_pkg::DIR_RESET;
        end else if (wr_lane0 && sel_dir_p2) begin
            dir_p2 <= fill_unused(pwdata[7:0], ppl_pkg::PORT2_MASK);
        end else if (bop_p2 && bop_tgt == ppl_pkg::PPL_TGT_DIR) begin
            dir_p2 <= fill_unused(bit_apply(dir_p2, bop_idx, bop_val),
                                  ppl_pkg::PORT2_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_p3 <= ppl_pkg::DIR_RESET;
        end else if (wr_lane0 && sel_dir_p3) begin
            dir_p3 <= fill_unused(pwdata[7:0], ppl_pkg::PORT3_MASK);
        end else if (bop_p3 && bop_tgt == ppl_pkg::PPL_TGT_DIR) begin
            dir_p3 <= fill_unused(bit_apply(dir_p3, bop_idx, bop_val),
                                  ppl_pkg::PORT3_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_p4 <= ppl_pkg::DIR_RESET;
        end else if (wr_lane0 && sel_dir_p4) begin
            dir_p4 <= fill_unused(pwdata[7:0], ppl_pkg::PORT4_MASK);
        end else if (bop_p4 && bop_tgt == ppl_pkg::PPL_TGT_DIR) begin
            dir_p4 <= fill_unused(bit_apply(dir_p4, bop_idx, bop_val),
                                  ppl_pkg::PORT4_MASK);
        end
    end

    // Pull-up selects, one per word in lane 0; missing pins are masked off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_select_port2 <= ppl_pkg::PULLUP_RESET;
        end else if (wr_lane0 && sel_pu_p2) begin
            pullup_select_port2 <= pwdata[7:0] & ppl_pkg::PORT2_MASK;
        end else if (bop_p2 && bop_tgt == ppl_pkg::PPL_TGT_PULLUP) begin
            pullup_select_port2 <= bit_apply(pullup_select_port2, bop_idx, bop_val)
                                   & ppl_pkg::PORT2_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_select_port3 <= ppl_pkg::PULLUP_RESET;
        end else if (wr_lane0 && sel_pu_p3) begin
            pullup_select_port3 <= pwdata[7:0] & ppl_pkg::PORT3_MASK;
        end else if (bop_p3 && bop_tgt == ppl_pkg::PPL_TGT_PULLUP) begin
            pullup_select_port3 <= bit_apply(pullup_select_port3, bop_idx, bop_val)
                                   & ppl_pkg::PORT3_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_select_port4 <= ppl_pkg::PULLUP_RESET;
        end else if (wr_lane0 && sel_pu_p4) begin
            pullup_select_port4 <= pwdata[7:0] & ppl_pkg::PORT4_MASK;
        end else if (bop_p4 && bop_tgt == ppl_pkg::PPL_TGT_PULLUP) begin
            pullup_select_port4 <= bit_apply(pullup_select_port4, bop_idx, bop_val)
                                   & ppl_pkg::PORT4_MASK;
        end
    end

    // Read mux and address check
    always_comb begin
        next_prdata = 32'h0000_0000;
        bad_addr    = 1'b0;
        if (sel_data_p2) begin
            next_prdata[7:0] = port_view(latch_p2, dir_p2, pin_p2, ppl_pkg::PORT2_MASK);
        end else if (sel_data_p3) begin
            next_prdata[7:0] = port_view(latch_p3, dir_p3, pin_p3, ppl_pkg::PORT3_MASK);
        end else if (sel_data_p4) begin
            next_prdata[7:0] = port_view(latch_p4, dir_p4, pin_p4, ppl_pkg::PORT4_MASK);
        end else if (sel_dir_p2) begin
            next_prdata[7:0] = dir_p2;
        end else if (sel_dir_p3) begin
            next_prdata[7:0] = dir_p3;
        end else if (sel_dir_p4) begin
            next_prdata[7:0] = dir_p4;
        end else if (sel_pu_p2) begin
            next_prdata[7:0] = pullup_select_port2;
        end else if (sel_pu_p3) begin
            next_prdata[7:0] = pullup_select_port3;
        end else if (sel_pu_p4) begin
            next_prdata[7:0] = pullup_select_port4;
        end else if (sel_bop) begin
            next_prdata = 32'h0000_0000;
        end else begin
            bad_addr = 1'b1;
        end
    end

    // Read data registered at the end of setup; holds until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // Pin drive, one clock behind the registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_p2 <= '0;
        end else begin
            pins_p2.drive     <= latch_p2;
            pins_p2.drive_en  <= ~dir_p2 & ppl_pkg::PORT2_MASK;
            pins_p2.pullup_en <= pullup_gate(pullup_select_port2, dir_p2);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_p3 <= '0;
        end else begin
            pins_p3.drive     <= latch_p3;
            pins_p3.drive_en  <= ~dir_p3 & ppl_pkg::PORT3_MASK;
            pins_p3.pullup_en <= pullup_gate(pullup_select_port3, dir_p3);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_p4 <= '0;
        end else begin
            pins_p4.drive     <= latch_p4;
            pins_p4.drive_en  <= ~dir_p4 & ppl_pkg::PORT4_MASK;
            pins_p4.pullup_en <= pullup_gate(pullup_select_port4, dir_p4);
        end
    end
endmodule // ppl_port_block

// ### bench/ppl_pin_model.sv
// Behavioural model of the circuitry attached to one port's pins
`timescale 1ns/1ps
module ppl_pin_model (
    input  wire logic            pclk,
    input  ppl_pkg::ppl_pin_out_s pins,
    input  wire logic [7:0]      ext_en,
    input  wire logic [7:0]      ext_level,
    output logic      [7:0]      level
);
    logic [7:0] flip = 8'h00;
    // A line nobody holds toggles so that a stale value never reads as data
    always @(posedge pclk) flip <= ~flip;
    assign level = (pins.drive_en & pins.drive)
                 | (~pins.drive_en & ext_en & ext_level)
                 | (~pins.drive_en & ~ext_en & (pins.pullup_en | flip));
endmodule // ppl_pin_model

// ### bench/ppl_port_block_checker.sv
// Concurrent checks on the port block's APB and pin-side ports
`timescale 1ns/1ps
module ppl_port_block_checker (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [17:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [3:0]       pstrb,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [7:0]       pin_in_p2,
    input wire logic [7:0]       pin_in_p3,
    input wire logic [7:0]       pin_in_p4,
    input ppl_pkg::ppl_pin_out_s pins_p2,
    input ppl_pkg::ppl_pin_out_s pins_p3,
    input ppl_pkg::ppl_pin_out_s pins_p4
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic wr;
    assign acc = psel && penable;
    assign wr  = acc && pwrite && pstrb[0];

    a_pullup_out_off: assert property ((pins_p4.pullup_en & pins_p4.drive_en) == 8'h00)
        else $error("pull-up left on at an output pin");
    a_pullup_unimpl: assert property (pins_p2.pullup_en[7:4] == 4'h0 &&
        (pins_p3.pullup_en & 8'hFB) == 8'h00) else $error("pull-up on a missing pin");
    a_latch_hold: assert property (!$past(wr, 2) |-> $stable(pins_p4.drive))
        else $error("latch changed without a write");
    a_latch_load: assert property (wr && paddr == {ppl_pkg::PORT_DATA_P4_IDX, 2'b00} |->
        ##2 pins_p4.drive == $past(pwdata[7:0], 2)) else $error("latch not loaded");
    a_dir_drive: assert property (wr && paddr == {ppl_pkg::PORT_DIR_P4_IDX, 2'b00} |->
        ##2 pins_p4.drive_en == ~$past(pwdata[7:0], 2)) else $error("driver enable wrong");
    a_pullup_sel: assert property (wr && paddr == {ppl_pkg::PULLUP_SEL_P4_IDX, 2'b00} |->
        ##2 pins_p4.pullup_en == ($past(pwdata[7:0], 2) & ~pins_p4.drive_en))
        else $error("pull-up select not applied");
    a_reset_state: assert property ($rose(presetn) |-> pins_p4.drive == 8'h00 &&
        pins_p4.drive_en == 8'h00 && pins_p4.pullup_en == 8'h00) else $error("bad reset state");
    a_unmapped_err: assert property (acc && paddr == 18'h00100 |->
        pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access accepted");

    c_bit_op: cover property (wr && paddr == {ppl_pkg::BIT_OP_IDX, 2'b00});
    c_data_read: cover property (acc && !pwrite && paddr == {ppl_pkg::PORT_DATA_P4_IDX, 2'b00});
    c_unmapped: cover property (acc && pslverr);
endmodule // ppl_port_block_checker

bind ppl_port_block ppl_port_block_checker i_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in_p2(pin_in_p2), .pin_in_p3(pin_in_p3), .pin_in_p4(pin_in_p4),
    .pins_p2(pins_p2), .pins_p3(pins_p3), .pins_p4(pins_p4));

// ### bench/testbench.sv
// Self-checking bench for the port pull-up and latch block
`timescale 1ns/1ps
module testbench;
    logic                  pclk = 1'b0;
    logic                  presetn = 1'b0;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [17:0]           paddr = 18'h00000;
    logic [7:0]            ext2 = 8'h00;
    logic [31:0]           pwdata = 32'h0;
    logic [3:0]            pstrb = 4'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [7:0]            lvl2;
    logic [7:0]            lvl3;
    logic [7:0]            lvl4;
    ppl_pkg::ppl_pin_out_s pins_p2;
    ppl_pkg::ppl_pin_out_s pins_p3;
    ppl_pkg::ppl_pin_out_s pins_p4;
    logic [31:0]           rd_data;
    logic                  rd_err;
    int                    num_errors = 0;
    int                    n_compared = 0;

    always #2.5 pclk = ~pclk;

    ppl_port_block i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in_p2(lvl2), .pin_in_p3(lvl3),
        .pin_in_p4(lvl4), .pins_p2(pins_p2), .pins_p3(pins_p3), .pins_p4(pins_p4));
    ppl_pin_model i_pin2 (.pclk(pclk), .pins(pins_p2), .ext_en(8'hFF), .ext_level(ext2),
        .level(lvl2));
    ppl_pin_model i_pin3 (.pclk(pclk), .pins(pins_p3), .ext_en(8'hFF), .ext_level(8'h00),
        .level(lvl3));
    // Even pins held low from outside, odd pins left to the pull-ups
    ppl_pin_model i_pin4 (.pclk(pclk), .pins(pins_p4), .ext_en(8'h55), .ext_level(8'h00),
        .level(lvl4));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [17:0] ba(input logic [15:0] idx);
        ba = {idx, 2'b00};
    endfunction

    task automatic apb(input logic [17:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [17:0] a, input logic [7:0] exp);
        apb(a, 1'b0, 32'h0, 4'h0);
        chk(rd_data[7:0], exp);
    endtask

    // Pins follow a register change one clock later; pin reads lag two more
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        num_errors++;
        final_report;
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(ba(ppl_pkg::PULLUP_SEL_P4_IDX), 8'h00);
        rd(ba(ppl_pkg::PORT_DIR_P4_IDX), 8'hFF);
        chk(pins_p4.drive, 8'h00);
        apb(ba(ppl_pkg::PULLUP_SEL_P4_IDX), 1'b1, 32'h000000AA, 4'h1);
        apb(ba(ppl_pkg::PULLUP_SEL_P2_IDX), 1'b1, 32'h000000FF, 4'h1);
        apb(ba(ppl_pkg::PULLUP_SEL_P3_IDX), 1'b1, 32'h000000FF, 4'h1);
        rd(ba(ppl_pkg::PULLUP_SEL_P2_IDX), 8'h0F);
        rd(ba(ppl_pkg::PULLUP_SEL_P3_IDX), 8'h04);
        ext2 <= 8'h05;
        settle(4);
        chk(pins_p4.pullup_en, 8'hAA);
        chk(pins_p2.pullup_en, 8'h0F);
        rd(ba(ppl_pkg::PORT_DATA_P2_IDX), 8'h05);
        rd(ba(ppl_pkg::PORT_DATA_P4_IDX), 8'hAA);
        apb(ba(ppl_pkg::PORT_DATA_P4_IDX), 1'b1, 32'h000000C3, 4'h1);
        settle(2);
        chk(pins_p4.drive, 8'hC3);
        chk(pins_p4.drive_en, 8'h00);
        rd(ba(ppl_pkg::PORT_DATA_P4_IDX), 8'hAA);
        apb(ba(ppl_pkg::PORT_DIR_P4_IDX), 1'b1, 32'h0000000F, 4'h1);
        settle(4);
        chk(pins_p4.drive_en, 8'hF0);
        chk(pins_p4.pullup_en, 8'h0A);
        rd(ba(ppl_pkg::PORT_DATA_P4_IDX), 8'hCA);
        apb(ba(ppl_pkg::BIT_OP_IDX), 1'b1, 32'h00000008, 4'h1);
        settle(2);
        chk(pins_p4.drive, 8'hCB);
        // Input bit 0 is held low outside, so the rewrite takes it from the pin
        apb(ba(ppl_pkg::BIT_OP_IDX), 1'b1, 32'h00000006, 4'h1);
        settle(4);
        chk(pins_p4.drive, 8'h8A);
        rd(ba(ppl_pkg::PORT_DATA_P4_IDX), 8'h8A);
        apb(ba(ppl_pkg::BIT_OP_IDX), 1'b1, 32'h00000028, 4'h1);
        rd(ba(ppl_pkg::PULLUP_SEL_P4_IDX), 8'hAB);
        apb(18'h00100, 1'b1, 32'h000000FF, 4'hF);
        chk({7'h00, rd_err}, 8'h01);
        rd(18'h00100, 8'h00);
        @(posedge pclk);
        presetn <= 1'b0;
        settle(2);
        chk(pins_p4.drive, 8'h00);
        chk(pins_p4.pullup_en, 8'h00);
        @(posedge pclk);
        presetn <= 1'b1;
        rd(ba(ppl_pkg::PULLUP_SEL_P4_IDX), 8'h00);
        final_report;
    end
endmodule // testbench
